// ---- logic/rxef_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module rxef_top
   import rxef_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Avalon-MM slave
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Receive FIFO write side
   input wire logic rxf_wr_i,
   input wire logic rxf_full_i,
   // Frame-end report
   input wire logic fr_valid_i,
   input wire rxef_frame_t fr_i,
   // Frame disposition
   output rxef_disp_t disp_o,
   // Transmit FIFO read side
   input wire logic txf_rd_i,
   input wire logic txf_empty_i,
   input wire logic tx_active_i,
   input wire logic tx_bit_tick_i,
   output logic tx_abort_o,
   // Threshold expiry pulses
   output logic [NSTAT-1:0] thr_hit_o
);

   // Registered state and its next value
   rxef_state_t st_ff;
   rxef_state_t nxt_st;

   // Decision helpers
   logic req;
   logic wr_en;
   logic preset;
   logic ovr_now;
   logic lenx;
   logic [MASK_W-1:0] err;
   logic [MASK_W-1:0] emask;
   logic filt_rej;
   logic masked_hit;
   logic discard_err;
   logic save;
   logic udr;
   logic [NSTAT-1:0] dec;
   logic [15:0] len_out;
   logic [31:0] cur;
   logic [31:0] wd;

   // Address of the i-th word in a register group
   function automatic logic [7:0] reg_addr(
      input logic [7:0] base,
      input int i
   );
      return base + 8'(i * REG_STRIDE);
   endfunction

   // Drop the odd byte, stay on whole words
   function automatic logic [15:0] even16(input logic [15:0] v);
      return {v[15:1], 1'b0};
   endfunction

   // Byte-lane merge of a write into a word
   function automatic logic [31:0] be_merge(
      input logic [31:0] old,
      input logic [31:0] nw,
      input logic [3:0] be
   );
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Read decode, also the base of a partial write
   function automatic logic [31:0] rd_word(input logic [7:0] a);
      logic [31:0] r;
      r = '0;
      case (a)
         OFF_CTRL: begin
            r[CB_PROMISC] = st_ff.promisc;
            r[CB_FILT] = st_ff.filt;
            r[CB_MULTI] = st_ff.multi;
         end
         OFF_STAT: begin
            r[SB_OVR] = st_ff.ovr_seen;
            r[SB_ABT] = (st_ff.abt == ABT_SEND);
         end
         OFF_PMASK: r[MASK_W-1:0] = st_ff.pmask;
         OFF_NMASK: r[MASK_W-1:0] = st_ff.nmask;
         OFF_FMASK: r = st_ff.fmask;
         OFF_FMATCH: r = st_ff.fmatch;
         default: ;
      endcase
      // Thresholds and live counters
      for (int i = 0; i < NSTAT; i++) begin
         if (a == reg_addr(OFF_THR, i)) begin
            r[15:0] = st_ff.thr[i];
         end
         if (a == reg_addr(OFF_CNT, i)) begin
            r[15:0] = st_ff.cnt[i];
         end
      end
      return r;
   endfunction

   // Bus handshake: one wait state per access
   assign req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & (st_ff.bus != BUS_ACK);
   assign wr_en = avs_write_i & (st_ff.bus == BUS_ACK);
   assign cur = rd_word(avs_address_i);
   assign wd = be_merge(cur, avs_writedata_i, avs_byteenable_i);
   // Preset reloads every counter on-line
   assign preset = wr_en & (avs_address_i == OFF_CTRL)
      & wd[CB_PRESET];

   // Overrun of this frame; a late write still counts
   assign ovr_now = st_ff.ovr_seen | (rxf_wr_i & rxf_full_i); // [RL18]

   // Length error: pool ran dry for nonprotocol frames in multibuffer mode, else N201 exceeded
   assign lenx = (fr_i.nonproto & st_ff.multi) ? // [RL11] [RL12]
      fr_i.pool_empty : fr_i.n201x;
   // Error vector in mask bit order
   assign err = {lenx, ovr_now, fr_i.abort, fr_i.crc}; // [RL8]

   // Mask only applies with valid bit and matching mode
   always_comb begin
      emask = '0;
      if (fr_i.mask_valid) begin
         if (fr_i.nonproto) begin
            emask = st_ff.nmask; // [RL9]
         end else begin
            emask = st_ff.pmask; // [RL10]
         end
      end
   end

   // Filter on the first 32 bits of the frame
   assign filt_rej = st_ff.promisc & st_ff.filt // [RL15]
      & (|((fr_i.head ^ st_ff.fmatch) & st_ff.fmask));

   // Any masked error keeps the frame
   assign masked_hit = |(err & emask); // [RL4] [RL7]
   assign discard_err = (|err) & ~masked_hit; // [RL7]
   assign save = ~filt_rej & ~fr_i.nobuf
      & ((err == '0) | masked_hit);

   // Stored length follows the first error in priority
   always_comb begin
      len_out = fr_i.len;
      if (err[MB_OVR]) begin
         len_out = fr_i.ovr_len; // [RL6] [RL2] [RL13]
      end else if (err[MB_ABT]) begin
         if (fr_i.nonproto) begin
            len_out = 16'(fr_i.len + CRC_BYTES); // [RL14]
         end else begin
            len_out = even16(fr_i.len); // [RL3]
         end
      end else if (err[MB_LEN]) begin
         if (!fr_i.nonproto) begin
            len_out = even16(fr_i.n201); // [RL1]
         end else if (!st_ff.multi) begin
            len_out = fr_i.n201; // [RL11]
         end
      end
   end

   // Underrun: empty read mid-frame, not while aborting
   assign udr = txf_rd_i & txf_empty_i & tx_active_i // [RL19]
      & (st_ff.abt == ABT_IDLE);

   // Counter decrement events
   always_comb begin
      dec = '0;
      dec[ST_OVR] = fr_valid_i & err[MB_OVR] & discard_err;
      dec[ST_UDR] = udr; // [RL19]
      dec[ST_INACT] = fr_valid_i & fr_i.inactive; // [RL20]
      // LAPD-only counts
      dec[ST_BADADR] = fr_valid_i & fr_i.bad_addr // [RL21]
         & ~fr_i.nonproto;
      dec[ST_SHORT] = fr_valid_i & ~fr_i.nonproto // [RL21]
         & (fr_i.flag_bytes < SHORT_MIN);
      dec[ST_DROP] = fr_valid_i & fr_i.nobuf; // [RL22]
      // CRC count is one global counter
      dec[ST_CRC] = fr_valid_i & err[MB_CRC] // [RL23]
         & discard_err;
      dec[ST_ABT] = fr_valid_i & err[MB_ABT] // [RL22]
         & discard_err;
   end

   // Next-state logic for the whole block
   always_comb begin
      nxt_st = st_ff;
      nxt_st.hit = '0;
      nxt_st.disp.valid = 1'b0;
      // Bus sequencer
      case (st_ff.bus)
         BUS_IDLE: begin
            if (req) begin
               nxt_st.bus = BUS_ACK;
               nxt_st.rdata = avs_read_i ? cur : '0;
            end
         end
         BUS_ACK: nxt_st.bus = BUS_IDLE;
         default: nxt_st.bus = BUS_IDLE;
      endcase
      // Register writes
      if (wr_en) begin
         case (avs_address_i)
            OFF_CTRL: begin
               nxt_st.promisc = wd[CB_PROMISC];
               nxt_st.filt = wd[CB_FILT];
               nxt_st.multi = wd[CB_MULTI];
            end
            // Upper mask bits are not stored
            OFF_PMASK: nxt_st.pmask = wd[MASK_W-1:0]; // [RL5]
            OFF_NMASK: nxt_st.nmask = wd[MASK_W-1:0]; // [RL5]
            OFF_FMASK: nxt_st.fmask = wd;
            OFF_FMATCH: nxt_st.fmatch = wd;
            default: ;
         endcase
         for (int i = 0; i < NSTAT; i++) begin
            if (avs_address_i == reg_addr(OFF_THR, i)) begin
               nxt_st.thr[i] = wd[15:0];
            end
         end
      end
      // Down-counters; zero encodes 65536
      for (int i = 0; i < NSTAT; i++) begin
         if (preset) begin
            nxt_st.cnt[i] = st_ff.thr[i]; // [RL16]
         end else if (dec[i]) begin
            if (st_ff.cnt[i] == CNT_ONE) begin
               nxt_st.hit[i] = 1'b1; // [RL16]
               nxt_st.cnt[i] = st_ff.thr[i];
            end else begin
               // 0 - 1 wraps to 65535, as 65536 should
               nxt_st.cnt[i] = st_ff.cnt[i] - CNT_ONE; // [RL17]
            end
         end
      end
      // Overrun flag lives for one frame
      nxt_st.ovr_seen = fr_valid_i ? 1'b0 : ovr_now;
      // Frame disposition
      if (fr_valid_i) begin
         nxt_st.disp.valid = 1'b1;
         nxt_st.disp.save = save;
         nxt_st.disp.err_code = err; // [RL8]
         nxt_st.disp.len = len_out;
         nxt_st.disp.mark_fl = fr_i.nonproto & st_ff.multi
            & err[MB_LEN] & save; // [RL11]
         nxt_st.disp.ret_bufs = fr_i.nonproto & st_ff.multi
            & ~save; // [RL12]
      end
      // Abort of seven ones on the bit clock
      case (st_ff.abt)
         ABT_IDLE: begin
            if (udr) begin
               nxt_st.abt = ABT_SEND; // [RL19]
               nxt_st.abt_cnt = '0;
            end
         end
         ABT_SEND: begin
            if (tx_bit_tick_i) begin
               nxt_st.abt_cnt = st_ff.abt_cnt + 3'h1;
               if (st_ff.abt_cnt == ABORT_LAST) begin
                  nxt_st.abt = ABT_IDLE;
               end
            end
         end
         default: nxt_st.abt = ABT_IDLE;
      endcase
   end

   // State register; all-zero reset is a 65536 count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from flops
   assign avs_readdata_o = st_ff.rdata;
   assign disp_o = st_ff.disp;
   assign tx_abort_o = (st_ff.abt == ABT_SEND);
   assign thr_hit_o = st_ff.hit;

   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   AST_ERR_CODE: assert property ( // [RL8]
      fr_valid_i |=> disp_o.valid && disp_o.err_code == $past(err)
   ) else $error("error code not reported");

   AST_OVR_LEN: assert property ( // [RL2]
      fr_valid_i && err[MB_OVR]
      |=> disp_o.len == $past(fr_i.ovr_len)
   ) else $error("overrun length wrong");

   AST_CRC_DROP: assert property ( // [RL4]
      fr_valid_i && err == 4'h1 && !emask[MB_CRC] |=> !disp_o.save
   ) else $error("unmasked CRC frame saved");

   AST_SAVE_KEEP: assert property ( // [RL7]
      fr_valid_i && masked_hit && !preset
      |=> st_ff.cnt[ST_CRC] == $past(st_ff.cnt[ST_CRC])
   ) else $error("counter moved on saved frame");

   AST_MASK_GATE: assert property ( // [RL9] [RL10]
      fr_valid_i && !fr_i.mask_valid && err != 4'h0
      |=> !disp_o.save
   ) else $error("mask used without valid bit");

   AST_FILTER: assert property ( // [RL15]
      fr_valid_i && filt_rej |=> !disp_o.save
   ) else $error("filtered frame saved");

   AST_N201_EVEN: assert property ( // [RL1]
      fr_valid_i && err == 4'h8 && !fr_i.nonproto
      |=> disp_o.len == even16($past(fr_i.n201))
   ) else $error("protocol N201 length not even");

   AST_PRESET: assert property ( // [RL16]
      preset |=> st_ff.cnt == $past(st_ff.thr)
   ) else $error("preset did not reload");

   AST_BADADDR: assert property ( // [RL21]
      fr_valid_i && fr_i.nonproto && !preset
      |=> st_ff.cnt[ST_BADADR] == $past(st_ff.cnt[ST_BADADR])
   ) else $error("bad address counted off LAPD");

   AST_ABORT_END: assert property ( // [RL19]
      $fell(tx_abort_o)
      |-> $past(st_ff.abt_cnt) == ABORT_LAST && $past(tx_bit_tick_i)
   ) else $error("abort not seven bits");

endmodule
`default_nettype wire

// ---- logic/rxef_pkg.sv ----
// Contract
// RL1 - Length bit keeps oversize frames, even N201 bytes
// RL2 - Overrun bit keeps frame, length before overrun
// RL3 - Protocol abort kept, residual word omitted
// RL4 - Bit 0 keeps or drops CRC-error frames
// RL5 - Host writes zero into mask bits 15-4
// RL6 - Errors checked overrun, abort, CRC, length
// RL7 - Masked error saves; else drop and decrement
// RL8 - Every error reported in error code
// RL9 - Nonprotocol mask only if valid and nonprotocol
// RL10 - Protocol mask only if valid and protocol
// RL11 - Nonprotocol length set: N201 or queue partial
// RL12 - Nonprotocol length clear: drop, return buffers
// RL13 - Nonprotocol overrun bit keeps truncated frame
// RL14 - Nonprotocol abort keeps all, length plus CRC
// RL15 - Filter compares first 32 bits when enabled
// RL16 - Down-counters load, expire, reload, preset
// RL17 - Zero threshold means 65536 events
// RL18 - Overrun is write into full receive FIFO
// RL19 - Underrun counts and sends seven ones abort
// RL20 - Count frames with inactive connection id
// RL21 - Bad address and short only on LAPD
// RL22 - Count no-buffer drops and aborted frames
// RL23 - CRC errors counted globally only
package rxef_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam logic [7:0] OFF_PMASK = 8'h08;
   localparam logic [7:0] OFF_NMASK = 8'h0C;
   localparam logic [7:0] OFF_FMASK = 8'h10;
   localparam logic [7:0] OFF_FMATCH = 8'h14;
   localparam logic [7:0] OFF_THR = 8'h20;
   localparam logic [7:0] OFF_CNT = 8'h40;
   localparam int REG_STRIDE = 4;
   // Error mask fields
   localparam int MASK_W = 4;
   localparam int MB_CRC = 0;
   localparam int MB_ABT = 1;
   localparam int MB_OVR = 2;
   localparam int MB_LEN = 3;
   // Control fields
   localparam int CB_PROMISC = 0;
   localparam int CB_FILT = 1;
   localparam int CB_MULTI = 2;
   localparam int CB_PRESET = 3;
   // Status fields
   localparam int SB_OVR = 0;
   localparam int SB_ABT = 1;
   // Statistics counters, interrupt bit order
   localparam int NSTAT = 8;
   localparam int ST_OVR = 0;
   localparam int ST_UDR = 1;
   localparam int ST_INACT = 2;
   localparam int ST_BADADR = 3;
   localparam int ST_DROP = 4;
   localparam int ST_SHORT = 5;
   localparam int ST_CRC = 6;
   localparam int ST_ABT = 7;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   // Frame figures
   localparam logic [15:0] CRC_BYTES = 16'h0002;
   localparam logic [15:0] SHORT_MIN = 16'h0005;
   localparam int ABORT_ONES = 7;
   localparam logic [2:0] ABORT_LAST = 3'(ABORT_ONES - 1);
   // Bus and abort sequencers
   typedef enum logic {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} rxef_bus_t;
   typedef enum logic {ABT_IDLE = 1'b0, ABT_SEND = 1'b1} rxef_abt_t;
   // Frame-end report from the receiver
   typedef struct packed {
      logic nonproto;
      logic mask_valid;
      logic abort;
      logic crc;
      logic n201x;
      logic pool_empty;
      logic nobuf;
      logic inactive;
      logic bad_addr;
      logic [15:0] len;
      logic [15:0] ovr_len;
      logic [15:0] n201;
      logic [15:0] flag_bytes;
      logic [31:0] head;
   } rxef_frame_t;
   // Disposition of one frame
   typedef struct packed {
      logic valid;
      logic save;
      logic mark_fl;
      logic ret_bufs;
      logic [MASK_W-1:0] err_code;
      logic [15:0] len;
   } rxef_disp_t;
   // Whole block state
   typedef struct packed {
      rxef_bus_t bus;
      logic [31:0] rdata;
      logic [MASK_W-1:0] pmask;
      logic [MASK_W-1:0] nmask;
      logic [31:0] fmask;
      logic [31:0] fmatch;
      logic promisc;
      logic filt;
      logic multi;
      logic [NSTAT-1:0][15:0] thr;
      logic [NSTAT-1:0][15:0] cnt;
      logic [NSTAT-1:0] hit;
      logic ovr_seen;
      rxef_disp_t disp;
      rxef_abt_t abt;
      logic [2:0] abt_cnt;
   } rxef_state_t;
endpackage

// ---- verif/rxef_line_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Far end of the transmit line: paces bit times, counts forced ones
module rxef_line_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Line side
   input wire logic tx_abort_i,
   output logic tick_o,
   output logic [7:0] ones_o
);
   logic [1:0] div_ff; // Bit time divider
   // One bit time every four clocks, running free like a line clock
   always_ff @(posedge clk_i) begin
      div_ff <= rst_i ? 2'h0 : div_ff + 2'h1;
   end
   assign tick_o = (div_ff == 2'h3);
   // Ones seen while the line is forced high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ones_o <= 8'h00;
      end else if (tick_o && tx_abort_i) begin
         ones_o <= ones_o + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ---- verif/tb_rxef_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_rxef_top;
   import rxef_pkg::*;
   // Clock, reset, bus
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] adr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic wait_o;
   // Receive, frame and transmit sides
   logic rxw = 1'b0;
   logic rxf = 1'b0;
   logic fv = 1'b0;
   rxef_frame_t fr = '0;
   rxef_disp_t disp;
   logic trd = 1'b0;
   logic tem = 1'b0;
   logic tact = 1'b0;
   logic tick;
   logic abt;
   logic [NSTAT-1:0] hit;
   logic [NSTAT-1:0] hits = '0; // Sticky record of expiries
   logic [7:0] ones;
   logic [1:0] xf = 2'b00; // Inactive id and bad address of next frame
   int fail_count = 0;
   int compares = 0;
   logic [31:0] v;
   localparam logic [7:0] CC = 8'(OFF_CNT + REG_STRIDE * ST_CRC);
   always #5 clk = ~clk;
   // Cleared only by reset, so each check expects the running total
   always @(posedge clk) hits <= rst ? '0 : (hits | hit);
   rxef_top i_rxef_top (
      .clk_i(clk), .rst_i(rst),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
      .rxf_wr_i(rxw), .rxf_full_i(rxf),
      .fr_valid_i(fv), .fr_i(fr), .disp_o(disp),
      .txf_rd_i(trd), .txf_empty_i(tem), .tx_active_i(tact),
      .tx_bit_tick_i(tick), .tx_abort_o(abt), .thr_hit_o(hit)
   );
   rxef_line_model i_rxef_line_model (
      .clk_i(clk), .rst_i(rst), .tx_abort_i(abt),
      .tick_o(tick), .ones_o(ones)
   );
   // Verdict, reached from the end or from a timeout
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Single compare, four-state exact
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // Avalon access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      adr <= a;
      wdat <= d;
      rd <= !w;
      wr <= w;
      n = 0;
      // Waitrequest and read data as they stood at the edge
      do begin
         @(posedge clk);
         n++;
      end while (wait_o !== 1'b0 && n < 50);
      if (n >= 50) begin
         fail_count++;
         summarize();
      end
      v = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // Host writes keep unused mask bits zero
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rc(input string n, input logic [7:0] a,
                     input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(n, e, v);
   endtask
   // One frame report, then its disposition a cycle later
   task automatic tf(input logic [6:0] fl, input logic [15:0] ln,
                     input logic [31:0] hd, input logic ov,
                     input logic [2:0] s, input logic [3:0] c,
                     input logic [15:0] l);
      rxef_frame_t f;
      f = '0;
      {f.nonproto, f.mask_valid, f.abort, f.crc} = fl[6:3];
      {f.n201x, f.pool_empty, f.nobuf} = fl[2:0];
      {f.inactive, f.bad_addr} = xf;
      f.len = ln;
      f.ovr_len = 16'h0006;
      f.n201 = 16'h000B;
      f.flag_bytes = ln + CRC_BYTES;
      f.head = hd;
      @(posedge clk);
      fr <= f;
      fv <= 1'b1;
      rxw <= ov;
      rxf <= ov;
      @(posedge clk);
      fv <= 1'b0;
      rxw <= 1'b0;
      rxf <= 1'b0;
      #1 chk("disp valid", 32'h0000_0001, {31'h0, disp.valid});
      chk("disposition", {9'h0, s, c, l}, {9'h0, disp.save,
          disp.mark_fl, disp.ret_bufs, disp.err_code, disp.len});
   endtask
   // Expiry record after one more edge
   task automatic hchk(input logic [7:0] e);
      @(posedge clk);
      #1 chk("expiries", {24'h0, e}, {24'h0, hits});
   endtask
   // Bounded wait for a level on the abort line
   task automatic wait_abt(input logic lv);
      int n;
      n = 0;
      while (abt !== lv && n < 200) begin
         @(posedge clk);
         #1 n++;
      end
      if (n >= 200) begin
         fail_count++;
         summarize();
      end
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      // Reset values and plain access
      rc("pmask", OFF_PMASK, 32'h0000_0000);
      rc("crc count", CC, 32'h0000_0000);
      rc("unmapped", 8'hFC, 32'h0000_0000);
      w(OFF_FMASK, 32'hFFFF_0000);
      rc("fmask", OFF_FMASK, 32'hFFFF_0000);
      w(8'(OFF_THR + REG_STRIDE * ST_CRC), 32'h0000_0002);
      w(8'(OFF_THR + REG_STRIDE * ST_SHORT), 32'h0000_0001);
      w(8'(OFF_THR + REG_STRIDE * ST_UDR), 32'h0000_0001);
      $display("Test registers done");
      // Protocol mask, one bit at a time
      tf(7'h28, 16'h0020, 0, 0, 3'h0, 4'h1, 16'h0020);
      rc("crc count", CC, 32'h0000_FFFF);
      w(OFF_PMASK, 32'h0000_0001);
      tf(7'h28, 16'h0020, 0, 0, 3'h4, 4'h1, 16'h0020);
      tf(7'h08, 16'h0020, 0, 0, 3'h0, 4'h1, 16'h0020);
      tf(7'h68, 16'h0020, 0, 0, 3'h0, 4'h1, 16'h0020);
      tf(7'h28, 16'h0020, 0, 1, 3'h4, 4'h5, 16'h0006);
      w(OFF_PMASK, 32'h0000_0002);
      tf(7'h38, 16'h0021, 0, 0, 3'h4, 4'h3, 16'h0020);
      w(OFF_PMASK, 32'h0000_0004);
      tf(7'h20, 16'h0020, 0, 1, 3'h4, 4'h4, 16'h0006);
      w(OFF_PMASK, 32'h0000_0008);
      tf(7'h24, 16'h0028, 0, 0, 3'h4, 4'h8, 16'h000A);
      $display("Test protocol mask done");
      // Counters: preset, discard decrements, expiry reloads
      w(OFF_PMASK, 32'h0000_0000);
      w(OFF_CTRL, 32'h0000_0008);
      rc("crc count", CC, 32'h0000_0002);
      tf(7'h28, 16'h0020, 0, 0, 3'h0, 4'h1, 16'h0020);
      rc("crc count", CC, 32'h0000_0001);
      hchk(8'h00);
      tf(7'h28, 16'h0020, 0, 0, 3'h0, 4'h1, 16'h0020);
      rc("crc count", CC, 32'h0000_0002);
      hchk(8'h40);
      w(OFF_PMASK, 32'h0000_0001);
      tf(7'h28, 16'h0020, 0, 0, 3'h4, 4'h1, 16'h0020);
      rc("crc count", CC, 32'h0000_0002);
      $display("Test counters done");
      // Nonprotocol mask, single and multibuffer
      w(OFF_NMASK, 32'h0000_0002);
      tf(7'h70, 16'h0009, 0, 0, 3'h4, 4'h2, 16'h000B);
      w(OFF_NMASK, 32'h0000_0004);
      tf(7'h60, 16'h0020, 0, 1, 3'h4, 4'h4, 16'h0006);
      w(OFF_NMASK, 32'h0000_0008);
      tf(7'h64, 16'h0028, 0, 0, 3'h4, 4'h8, 16'h000B);
      w(OFF_CTRL, 32'h0000_0004);
      tf(7'h66, 16'h000B, 0, 0, 3'h6, 4'h8, 16'h000B);
      w(OFF_NMASK, 32'h0000_0000);
      tf(7'h66, 16'h000B, 0, 0, 3'h1, 4'h8, 16'h000B);
      $display("Test nonprotocol mask done");
      // Filter on the first 32 bits
      w(OFF_FMATCH, 32'hABCD_0000);
      w(OFF_CTRL, 32'h0000_0003);
      tf(7'h20, 16'h0020, 32'hABCD_1234, 0, 3'h4, 4'h0, 16'h0020);
      tf(7'h20, 16'h0020, 32'h1234_ABCD, 0, 3'h0, 4'h0, 16'h0020);
      w(OFF_CTRL, 32'h0000_0001);
      tf(7'h20, 16'h0020, 32'h1234_ABCD, 0, 3'h4, 4'h0, 16'h0020);
      $display("Test filter done");
      // Short frames count on protocol links only
      tf(7'h60, 16'h0002, 0, 0, 3'h4, 4'h0, 16'h0002);
      hchk(8'h40);
      tf(7'h20, 16'h0002, 0, 0, 3'h4, 4'h0, 16'h0002);
      hchk(8'h60);
      $display("Test short frames done");
      // Underrun mid-frame forces seven ones
      @(posedge clk);
      trd <= 1'b1;
      tem <= 1'b1;
      tact <= 1'b1;
      @(posedge clk);
      trd <= 1'b0;
      #1 chk("abort", 32'h0000_0001, {31'h0, abt});
      rc("status", OFF_STAT, 32'h0000_0002);
      wait_abt(1'b0);
      chk("ones", 32'h0000_0007, {24'h0, ones});
      hchk(8'h62);
      $display("Test underrun done");
      // Inactive, bad address, drop, abort and overrun counters expire on their own events
      for (int i = 0; i < NSTAT; i++) begin
         w(8'(OFF_THR + REG_STRIDE * i), 32'h0000_0001);
      end
      w(OFF_CTRL, 32'h0000_0008);
      xf = 2'b10;
      tf(7'h20, 16'h0020, 0, 0, 3'h4, 4'h0, 16'h0020);
      hchk(8'h66);
      xf = 2'b01;
      tf(7'h60, 16'h0020, 0, 0, 3'h4, 4'h0, 16'h0020);
      hchk(8'h66);
      tf(7'h20, 16'h0020, 0, 0, 3'h4, 4'h0, 16'h0020);
      hchk(8'h6E);
      xf = 2'b00;
      tf(7'h21, 16'h0020, 0, 0, 3'h0, 4'h0, 16'h0020);
      hchk(8'h7E);
      tf(7'h30, 16'h0020, 0, 0, 3'h0, 4'h2, 16'h0020);
      hchk(8'hFE);
      tf(7'h20, 16'h0020, 0, 1, 3'h0, 4'h4, 16'h0006);
      hchk(8'hFF);
      $display("Test statistics done");
      summarize();
   end
endmodule
`default_nettype wire
